// File: hw/abd_pkg.sv
// Constants and types for the analog board address decoder
package abd_pkg;
	localparam int unsigned ADDR_W   = 12;
	localparam int unsigned DATA_W   = 8;
	localparam int unsigned APB_AW   = 8;

	// Eight-channel board: fixed bits and their values
	localparam logic [11:0] EIGHT_FIX_MASK = 12'hEC0;
	localparam logic [11:0] EIGHT_FIX_VAL  = 12'h080;
	localparam int unsigned EIGHT_CODE3_POS = 8;
	localparam int unsigned EIGHT_CODE2_POS = 5;
	localparam int unsigned EIGHT_JMP1_POS  = 4;
	localparam int unsigned EIGHT_CODE1_POS = 3;
	localparam int unsigned EIGHT_CODE0_POS = 2;
	localparam int unsigned EIGHT_RSEL_POS  = 1;
	localparam int unsigned EIGHT_JMP2_POS  = 0;

	// Eleven-channel board: fixed bits and their values
	localparam logic [11:0] ELEVEN_FIX_MASK = 12'hFF0;
	localparam logic [11:0] ELEVEN_FIX_VAL  = 12'h0C0;
	localparam int unsigned ELEVEN_CODE_POS = 2;
	localparam int unsigned ELEVEN_HIGH_POS = 1;
	localparam int unsigned ELEVEN_LOW_POS  = 0;
	localparam logic [3:0]  ELEVEN_LAST_CH  = 4'hA;

	// Register-select values
	localparam logic RSEL_CHANNEL = 1'b0;
	localparam logic RSEL_SERIAL  = 1'b1;

	// APB register offsets
	localparam logic [7:0] OFS_CTRL   = 8'h00;
	localparam logic [7:0] OFS_STATUS = 8'h04;
	localparam logic [7:0] OFS_SERIAL = 8'h08;
	localparam logic [7:0] OFS_ADDR   = 8'h0C;

	// Control fields and reset value
	localparam int unsigned CTRL_EIGHT_EN_POS  = 0;
	localparam int unsigned CTRL_ELEVEN_EN_POS = 1;
	localparam logic [1:0]  CTRL_RESET         = 2'h3;

	// Status fields
	localparam int unsigned ST_MATCH8_POS  = 0;
	localparam int unsigned ST_MATCH11_POS = 1;
	localparam int unsigned ST_RSEL_POS    = 2;
	localparam int unsigned ST_CHAN8_POS   = 4;
	localparam int unsigned ST_CHAN11_POS  = 8;
	localparam int unsigned ST_LOGIC_POS   = 16;

	// Reset values of board registers
	localparam logic [2:0] CHAN8_RESET  = 3'h0;
	localparam logic [3:0] CHAN11_RESET = 4'h0;
	localparam logic [7:0] SERIAL_RESET = 8'h00;

	// Expansion-bus request from the controller
	typedef struct packed {
		logic [11:0] addr;
		logic [7:0]  data;
		logic        addr_stb;
		logic        wr_stb;
		logic        rd_stb;
		logic        bus_reset;
	} abd_req_t;

	// Expansion-bus read answer
	typedef struct packed {
		logic [7:0] data;
		logic       oe;
	} abd_rsp_t;
endpackage : abd_pkg

// File: hw/abd_decoder.sv
// Address decoder and registers for the two analog input boards
// Summary of operation
// - The eight-channel board answers only addresses 000p 10px ppRy built from its code, jumpers and select bit.
// - The eight-channel board's four-bit code is fixed by the decoder variant, one of sixteen.
// - Bit 0 of the eight-channel address is one when the second jumper pair is open, zero when fitted.
// - Bit 4 of the eight-channel address is one when the first jumper pair is open, zero when fitted.
// - On a match the select bit picks the channel register at zero and the serial control register at one.
// - The channel register routes one of eight analog inputs to the converter.
// - The second register is the serial control register for the converter link.
// - The eleven-channel board answers only addresses 0000 1100 ppxy.
// - The eleven-channel board's two-bit code is fixed by the variant, one of four.
// - Bit 1 of the eleven-channel address is one when the high jumper is open, else zero.
// - Bit 0 of the eleven-channel address is one when the low jumper is open, else zero.
//
// Chosen here: the APB slave port and the register offsets.
module abd_decoder #(
	parameter logic [3:0] EIGHT_CODE  = 4'h0,
	parameter logic [1:0] ELEVEN_CODE = 2'h0
) (
	input  wire logic              sys_clk,
	input  wire logic              sys_rst,
	input  wire abd_pkg::abd_req_t bus_req,
	output abd_pkg::abd_rsp_t      bus_rsp_ff,
	input  wire logic [1:0]        board_jumper_block_fitted,
	input  wire logic              low_id_jumper_fitted,
	input  wire logic              high_id_jumper_fitted,
	output logic [2:0]             channel_select_reg_ff,
	output logic [7:0]             serial_ctrl_reg_ff,
	output logic [3:0]             eleven_chan_ff,
	output logic                   match_eight_ff,
	output logic                   match_eleven_ff,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [7:0]        paddr,
	input  wire logic [31:0]       pwdata,
	output logic [31:0]            prdata_ff,
	output logic                   pready_ff,
	output logic                   pslverr_ff
);

	timeunit 1ns;
	timeprecision 1ps;

	// Register offset check, used for both read and write
	function automatic logic apb_hit(input logic [7:0] a, input logic [7:0] ofs);
		apb_hit = (a == ofs);
	endfunction : apb_hit

	// Expected eight-channel address with select bit cleared
	function automatic logic [11:0] eight_addr(input logic [3:0] code, input logic [1:0] jf);
		logic [11:0] a;
		a = abd_pkg::EIGHT_FIX_VAL;
		a[abd_pkg::EIGHT_CODE3_POS] = code[3];
		a[abd_pkg::EIGHT_CODE2_POS] = code[2];
		a[abd_pkg::EIGHT_CODE1_POS] = code[1];
		a[abd_pkg::EIGHT_CODE0_POS] = code[0];
		a[abd_pkg::EIGHT_JMP1_POS]  = ~jf[0];
		a[abd_pkg::EIGHT_JMP2_POS]  = ~jf[1];
		eight_addr = a;
	endfunction : eight_addr

	logic [1:0]  ctrl_ff;
	logic [1:0]  nxt_ctrl;
	logic [11:0] last_addr_ff;
	logic [11:0] nxt_last_addr;
	logic        rsel_ff;
	logic        nxt_rsel;
	logic        nxt_match_eight;
	logic        nxt_match_eleven;
	logic [2:0]  nxt_chan8;
	logic [7:0]  nxt_serial;
	logic [3:0]  nxt_chan11;
	abd_pkg::abd_rsp_t nxt_rsp;
	logic [31:0] nxt_prdata;
	logic        nxt_pready;
	logic        nxt_pslverr;
	logic [11:0] exp8;
	logic [11:0] exp11;
	logic [11:0] addr_no_r;
	logic [5:0]  logical8;
	logic        hit8;
	logic        hit11;
	logic        apb_access;
	logic        apb_known;

	// Static address patterns
	always_comb
	begin
		exp8  = eight_addr(EIGHT_CODE, board_jumper_block_fitted);
		exp11 = abd_pkg::ELEVEN_FIX_VAL;
		exp11[abd_pkg::ELEVEN_CODE_POS +: 2] = ELEVEN_CODE;
		exp11[abd_pkg::ELEVEN_HIGH_POS]      = ~high_id_jumper_fitted;
		exp11[abd_pkg::ELEVEN_LOW_POS]       = ~low_id_jumper_fitted;
		addr_no_r = bus_req.addr;
		addr_no_r[abd_pkg::EIGHT_RSEL_POS] = 1'b0;
		hit8  = (addr_no_r == exp8) && ctrl_ff[abd_pkg::CTRL_EIGHT_EN_POS];
		hit11 = (bus_req.addr == exp11) && ctrl_ff[abd_pkg::CTRL_ELEVEN_EN_POS];
		logical8 = {EIGHT_CODE, exp8[abd_pkg::EIGHT_JMP1_POS], exp8[abd_pkg::EIGHT_JMP2_POS]};
	end

	// Expansion-bus side: address match and board registers
	always_comb
	begin
		nxt_last_addr    = last_addr_ff;
		nxt_rsel         = rsel_ff;
		nxt_match_eight  = match_eight_ff;
		nxt_match_eleven = match_eleven_ff;
		nxt_chan8        = channel_select_reg_ff;
		nxt_serial       = serial_ctrl_reg_ff;
		nxt_chan11       = eleven_chan_ff;
		nxt_rsp.data     = 8'h00;
		nxt_rsp.oe       = 1'b0;
		if (bus_req.bus_reset)
		begin
			nxt_match_eight  = 1'b0;
			nxt_match_eleven = 1'b0;
			nxt_rsel         = abd_pkg::RSEL_CHANNEL;
			nxt_chan8        = abd_pkg::CHAN8_RESET;
			nxt_serial       = abd_pkg::SERIAL_RESET;
			nxt_chan11       = abd_pkg::CHAN11_RESET;
		end
		else if (bus_req.addr_stb)
		begin
			nxt_last_addr    = bus_req.addr;
			nxt_match_eight  = hit8;
			nxt_match_eleven = hit11;
			nxt_rsel         = bus_req.addr[abd_pkg::EIGHT_RSEL_POS];
		end
		else if (bus_req.wr_stb)
		begin
			// Writes while another board is addressed are ignored
			if (match_eight_ff && rsel_ff == abd_pkg::RSEL_CHANNEL)
				nxt_chan8 = bus_req.data[2:0];
			else if (match_eight_ff && rsel_ff == abd_pkg::RSEL_SERIAL)
				nxt_serial = bus_req.data;
			else if (match_eleven_ff && bus_req.data[3:0] <= abd_pkg::ELEVEN_LAST_CH)
				nxt_chan11 = bus_req.data[3:0];
		end
		else if (bus_req.rd_stb)
		begin
			if (match_eight_ff)
			begin
				nxt_rsp.oe   = 1'b1;
				nxt_rsp.data = (rsel_ff == abd_pkg::RSEL_SERIAL) ? serial_ctrl_reg_ff
				               : {5'h00, channel_select_reg_ff};
			end
			else if (match_eleven_ff)
			begin
				nxt_rsp.oe   = 1'b1;
				nxt_rsp.data = {4'h0, eleven_chan_ff};
			end
		end
	end

	always_ff @(posedge sys_clk)
	begin
		if (sys_rst)
		begin
			last_addr_ff          <= 12'h000;
			rsel_ff               <= abd_pkg::RSEL_CHANNEL;
			match_eight_ff        <= 1'b0;
			match_eleven_ff       <= 1'b0;
			channel_select_reg_ff <= abd_pkg::CHAN8_RESET;
			serial_ctrl_reg_ff    <= abd_pkg::SERIAL_RESET;
			eleven_chan_ff        <= abd_pkg::CHAN11_RESET;
			bus_rsp_ff            <= '0;
		end
		else
		begin
			last_addr_ff          <= nxt_last_addr;
			rsel_ff               <= nxt_rsel;
			match_eight_ff        <= nxt_match_eight;
			match_eleven_ff       <= nxt_match_eleven;
			channel_select_reg_ff <= nxt_chan8;
			serial_ctrl_reg_ff    <= nxt_serial;
			eleven_chan_ff        <= nxt_chan11;
			bus_rsp_ff            <= nxt_rsp;
		end
	end

	// APB slave, one wait state
	always_comb
	begin
		apb_access  = psel && penable && !pready_ff;
		apb_known   = apb_hit(paddr, abd_pkg::OFS_CTRL) || apb_hit(paddr, abd_pkg::OFS_STATUS)
		              || apb_hit(paddr, abd_pkg::OFS_SERIAL) || apb_hit(paddr, abd_pkg::OFS_ADDR);
		nxt_ctrl    = ctrl_ff;
		nxt_prdata  = 32'h0000_0000;
		nxt_pready  = apb_access;
		nxt_pslverr = apb_access && !apb_known;
		if (apb_access && pwrite && apb_hit(paddr, abd_pkg::OFS_CTRL))
			nxt_ctrl = pwdata[1:0];
		if (apb_access && !pwrite)
		begin
			if (apb_hit(paddr, abd_pkg::OFS_CTRL))
				nxt_prdata[1:0] = ctrl_ff;
			else if (apb_hit(paddr, abd_pkg::OFS_STATUS))
			begin
				nxt_prdata[abd_pkg::ST_MATCH8_POS]       = match_eight_ff;
				nxt_prdata[abd_pkg::ST_MATCH11_POS]      = match_eleven_ff;
				nxt_prdata[abd_pkg::ST_RSEL_POS]         = rsel_ff;
				nxt_prdata[abd_pkg::ST_CHAN8_POS +: 3]   = channel_select_reg_ff;
				nxt_prdata[abd_pkg::ST_CHAN11_POS +: 4]  = eleven_chan_ff;
				nxt_prdata[abd_pkg::ST_LOGIC_POS +: 6]   = logical8;
			end
			else if (apb_hit(paddr, abd_pkg::OFS_SERIAL))
				nxt_prdata[7:0] = serial_ctrl_reg_ff;
			else if (apb_hit(paddr, abd_pkg::OFS_ADDR))
				nxt_prdata[11:0] = last_addr_ff;
		end
	end

	always_ff @(posedge sys_clk)
	begin
		if (sys_rst)
		begin
			ctrl_ff    <= abd_pkg::CTRL_RESET;
			prdata_ff  <= 32'h0000_0000;
			pready_ff  <= 1'b0;
			pslverr_ff <= 1'b0;
		end
		else
		begin
			ctrl_ff    <= nxt_ctrl;
			prdata_ff  <= nxt_prdata;
			pready_ff  <= nxt_pready;
			pslverr_ff <= nxt_pslverr;
		end
	end

endmodule : abd_decoder

// File: verification/abd_props.sv
// Checker for the decoder ports
module abd_props #(
	parameter logic [3:0] EIGHT_CODE  = 4'h0,
	parameter logic [1:0] ELEVEN_CODE = 2'h0
) (
	input wire logic              sys_clk,
	input wire logic              sys_rst,
	input wire abd_pkg::abd_req_t bus_req,
	input wire abd_pkg::abd_rsp_t bus_rsp_ff,
	input wire logic [1:0]        board_jumper_block_fitted,
	input wire logic              low_id_jumper_fitted,
	input wire logic              high_id_jumper_fitted,
	input wire logic [2:0]        channel_select_reg_ff,
	input wire logic [7:0]        serial_ctrl_reg_ff,
	input wire logic              match_eight_ff,
	input wire logic              match_eleven_ff
);
	timeunit 1ns;
	timeprecision 1ps;
	logic        rsel_ff, nxt_rsel, a8, a11, st, tk, rm;
	logic [11:0] a;
	logic [7:0]  d;
	assign a = bus_req.addr;
	assign d = bus_req.data;
	assign a8 = (a & abd_pkg::EIGHT_FIX_MASK) == abd_pkg::EIGHT_FIX_VAL
		&& {a[8], a[5], a[3], a[2]} == EIGHT_CODE
		&& a[4] == !board_jumper_block_fitted[0] && a[0] == !board_jumper_block_fitted[1];
	assign a11 = (a & abd_pkg::ELEVEN_FIX_MASK) == abd_pkg::ELEVEN_FIX_VAL
		&& a[3:2] == ELEVEN_CODE && a[1] == !high_id_jumper_fitted
		&& a[0] == !low_id_jumper_fitted;
	assign st = bus_req.addr_stb && !bus_req.bus_reset;
	assign tk = !bus_req.addr_stb && !bus_req.bus_reset;
	assign rm = bus_req.rd_stb && (match_eight_ff || match_eleven_ff);
	// Select bit latched with the address
	always_comb nxt_rsel = (sys_rst || bus_req.bus_reset) ? 1'b0 : st ? a[1] : rsel_ff;
	always_ff @(posedge sys_clk) rsel_ff <= nxt_rsel;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (sys_rst);
	a_eight_match: assert property (st && !a8 |=> !match_eight_ff)
		else $error("eight board matched a foreign address");
	a_eleven_match: assert property (st && !a11 |=> !match_eleven_ff)
		else $error("eleven board matched a foreign address");
	a_bus_clear: assert property (bus_req.bus_reset |=> !match_eight_ff && !match_eleven_ff
		&& channel_select_reg_ff == abd_pkg::CHAN8_RESET) else $error("bus reset not clearing");
	a_write_nomatch: assert property (tk && bus_req.wr_stb && !match_eight_ff
		|=> $stable(channel_select_reg_ff) && $stable(serial_ctrl_reg_ff))
		else $error("write taken without match");
	a_chan_write: assert property (tk && bus_req.wr_stb && match_eight_ff && !rsel_ff
		|=> channel_select_reg_ff == 3'($past(d)) && $stable(serial_ctrl_reg_ff))
		else $error("channel write wrong");
	a_serial_write: assert property (tk && bus_req.wr_stb && match_eight_ff && rsel_ff
		|=> serial_ctrl_reg_ff == $past(d) && $stable(channel_select_reg_ff))
		else $error("serial write wrong");
	a_chan_hold: assert property (!bus_req.wr_stb && !bus_req.bus_reset
		|=> $stable(channel_select_reg_ff)) else $error("channel changed unasked");
	a_read_oe: assert property (tk && !bus_req.wr_stb |=> bus_rsp_ff.oe == $past(rm))
		else $error("read answer wrong");
	a_read_chan: assert property (tk && !bus_req.wr_stb && rm && match_eight_ff && !rsel_ff
		|=> bus_rsp_ff.data == {5'h00, $past(channel_select_reg_ff)})
		else $error("channel read data wrong");
endmodule : abd_props

// File: verification/abd_host.sv
// Controller model driving the expansion bus
module abd_host #(
	parameter int SETTLE = 4
) (
	input wire logic          sys_clk,
	output abd_pkg::abd_req_t bus_req
);
	timeunit 1ns;
	timeprecision 1ps;
	initial bus_req = '0;
	// Strobes s: addr, write, read, bus reset
	task automatic send(input logic [11:0] a, input logic [7:0] d, input logic [3:0] s);
		@(posedge sys_clk);
		bus_req <= {a, d, s};
		@(posedge sys_clk);
		bus_req <= {~a, ~d, 4'h0}; // Released lines lose old value
	endtask : send
	// Logical number software gives an eight-channel board
	function automatic logic [5:0] logical_addr(input logic [11:0] a);
		logical_addr = {a[8], a[5], a[3], a[2], a[4], a[0]};
	endfunction : logical_addr
	task automatic settle();
		repeat (SETTLE) @(posedge sys_clk);
	endtask : settle
endmodule : abd_host

// File: verification/test_abd_decoder.sv
// Testbench for the analog board decoder
module test_abd_decoder;
	timeunit 1ns;
	timeprecision 1ps;
	logic sys_clk = 0, sys_rst = 1, psel = 0, penable = 0, pwrite = 0, er;
	logic low_id_jumper_fitted = 0, high_id_jumper_fitted = 0;
	logic match_eight_ff, match_eleven_ff, pready_ff, pslverr_ff;
	logic [1:0] board_jumper_block_fitted = '0;
	logic [7:0] paddr = '0, serial_ctrl_reg_ff;
	logic [31:0] pwdata = '0, prdata_ff, rd;
	logic [2:0] channel_select_reg_ff;
	logic [3:0] eleven_chan_ff;
	int fails = 0, samples_checked = 0;
	abd_pkg::abd_req_t bus_req;
	abd_pkg::abd_rsp_t bus_rsp_ff;
	// Row: address, jumpers fitted {pins3-4, pins1-2, low, high}, expected {m8, m11}
	localparam logic [19:0] ROWS [11] = '{20'h1_9502, 20'h1_9702, 20'h1_8542, 20'h1_9482,
		20'h1_9540, 20'h1_9100, 20'h0_CB01, 20'h0_CA21, 20'h0_C911, 20'h0_CB30, 20'h0_C700};
	always #20 sys_clk = ~sys_clk;
	abd_host host (.sys_clk, .bus_req);
	abd_decoder #(.EIGHT_CODE(4'h9), .ELEVEN_CODE(2'h2)) dut (.sys_clk, .sys_rst, .bus_req,
		.bus_rsp_ff, .board_jumper_block_fitted, .low_id_jumper_fitted, .high_id_jumper_fitted,
		.channel_select_reg_ff, .serial_ctrl_reg_ff, .eleven_chan_ff, .match_eight_ff,
		.match_eleven_ff, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata_ff, .pready_ff,
		.pslverr_ff);
	task test_done();
		$display("checked %0d fails %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : test_done
	task chk(input logic [31:0] g, input logic [31:0] e);
		samples_checked++;
		if (g !== e)
		begin
			fails++;
			$display("mismatch t=%0t got %h exp %h", $time, g, e);
		end
	endtask : chk
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge sys_clk);
		{psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
		@(posedge sys_clk);
		penable <= 1;
		n = 0;
		do
		begin
			@(posedge sys_clk);
			n++;
		end
		while (pready_ff !== 1'b1 && n < 20);
		if (n >= 20)
		begin
			fails++;
			test_done();
		end
		else
		begin
			rd = prdata_ff;
			er = pslverr_ff;
			{psel, penable} <= 2'b00;
		end
	endtask : apb
	initial
	begin
		repeat (3) @(posedge sys_clk);
		sys_rst <= 0;
		@(negedge sys_clk);
		chk({channel_select_reg_ff, serial_ctrl_reg_ff, match_eight_ff, bus_rsp_ff}, 0);
		apb(0, abd_pkg::OFS_CTRL, 0);
		chk(rd, 32'(abd_pkg::CTRL_RESET));
		$display("reset test done");
		for (int i = 0; i < 11; i++)
		begin
			host.send(12'h000, 8'h00, 4'h1);
			{board_jumper_block_fitted, low_id_jumper_fitted, high_id_jumper_fitted} <= ROWS[i][7:4];
			host.send(ROWS[i][19:8], 8'h00, 4'h8);
			@(negedge sys_clk);
			chk({match_eight_ff, match_eleven_ff}, ROWS[i][1:0]);
		end
		$display("address table done");
		host.send(12'h195, 8'h00, 4'h8);
		host.send(12'h000, 8'hFD, 4'h4);
		host.settle();
		host.send(12'h000, 8'h00, 4'h2);
		@(negedge sys_clk);
		chk(bus_rsp_ff, {8'h05, 1'b1});
		host.send(12'h197, 8'h00, 4'h8);
		host.send(12'h000, 8'hA6, 4'h4);
		@(negedge sys_clk);
		chk({serial_ctrl_reg_ff, channel_select_reg_ff}, {8'hA6, 3'h5});
		host.send(12'h191, 8'h00, 4'h8);
		host.send(12'h000, 8'h03, 4'h4);
		host.send(12'h000, 8'h00, 4'h2);
		@(negedge sys_clk);
		chk({serial_ctrl_reg_ff, channel_select_reg_ff, bus_rsp_ff.oe}, {8'hA6, 3'h5, 1'b0});
		host.send(12'h0CB, 8'h00, 4'h8);
		host.send(12'h000, 8'h0A, 4'h4);
		host.send(12'h000, 8'h0B, 4'h4);
		@(negedge sys_clk);
		chk(eleven_chan_ff, abd_pkg::ELEVEN_LAST_CH);
		host.send(12'h195, 8'h00, 4'h8);
		apb(0, abd_pkg::OFS_STATUS, 0);
		chk(rd, {10'h000, host.logical_addr(12'h195), 16'h0A51});
		apb(0, abd_pkg::OFS_SERIAL, 0);
		chk(rd, 32'h0000_00A6);
		chk(er, 0);
		apb(0, abd_pkg::OFS_ADDR, 0);
		chk(rd, 32'h0000_0195);
		host.send(12'h0CB, 8'h00, 4'h8);
		host.send(12'h000, 8'h00, 4'h2);
		@(negedge sys_clk);
		chk(bus_rsp_ff, {8'h0A, 1'b1});
		apb(1, 8'h10, 32'hFFFF_FFFF);
		chk(er, 1);
		apb(1, abd_pkg::OFS_CTRL, 0);
		host.send(12'h195, 8'h00, 4'h8);
		@(negedge sys_clk);
		chk(match_eight_ff, 0);
		$display("hand tests done");
		apb(1, abd_pkg::OFS_CTRL, 32'h0000_0003);
		host.send(12'h197, 8'h00, 4'h8);
		@(negedge sys_clk);
		chk(match_eight_ff, 1);
		host.send(12'h000, 8'h00, 4'h1);
		@(negedge sys_clk);
		chk({channel_select_reg_ff, serial_ctrl_reg_ff, match_eight_ff}, 0);
		$display("bus reset test done");
		host.send(12'h195, 8'h00, 4'h8);
		host.send(12'h000, 8'h03, 4'h4);
		@(negedge sys_clk);
		chk(channel_select_reg_ff, 3'h3);
		apb(1, abd_pkg::OFS_CTRL, 0);
		@(posedge sys_clk);
		sys_rst <= 1;
		@(posedge sys_clk);
		sys_rst <= 0;
		@(negedge sys_clk);
		chk({channel_select_reg_ff, serial_ctrl_reg_ff, match_eight_ff, bus_rsp_ff}, 0);
		apb(0, abd_pkg::OFS_CTRL, 0);
		chk(rd, 32'(abd_pkg::CTRL_RESET));
		$display("mid-run reset test done");
		test_done();
	end
endmodule : test_abd_decoder
bind abd_decoder abd_props #(.EIGHT_CODE(EIGHT_CODE), .ELEVEN_CODE(ELEVEN_CODE)) props_i (
	.sys_clk, .sys_rst, .bus_req, .bus_rsp_ff, .board_jumper_block_fitted, .low_id_jumper_fitted,
	.high_id_jumper_fitted, .channel_select_reg_ff, .serial_ctrl_reg_ff, .match_eight_ff,
	.match_eleven_ff);
